// ==== design/ccg_clock_gen.v ====
// Purpose: CPU clock select/divide and peripheral clock generation
// Assumes: Source clocks arrive as one-cycle tick enables, synchronous to I_CORE_CLK
// Notes: Every derived clock leaves as a one-cycle enable pulse, except the clock output pin, which copies I_ADDR_LATCH_STROBE in ALE bus mode
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "ccg_consts.vh"

module ccg_clock_gen (
   input wire I_CORE_CLK,
   input wire I_SYS_RST,
   input wire I_WB_CYC,
   input wire I_WB_STB,
   input wire I_WB_WE,
   input wire [7:0] I_WB_ADR,
   input wire [3:0] I_WB_SEL,
   input wire [31:0] I_WB_DAT,
   output reg [31:0] O_WB_DAT,
   output reg O_WB_ACK,
   input wire I_MAIN_TICK,
   input wire I_SUB_TICK,
   input wire I_OCO_TICK,
   input wire I_PLL_TICK,
   input wire I_MAIN_RUN,
   input wire I_SUB_RUN,
   input wire I_WAIT_MODE,
   input wire I_STOP_MODE,
   input wire I_EXP_MODE,
   input wire I_ADDR_LATCH_STROBE,
   output reg O_CPU_CLK,
   output reg O_WDT_CLK,
   output reg O_BUS_CLK,
   output reg O_F1,
   output reg O_F8,
   output reg O_F32,
   output reg O_F2N,
   output reg O_FAD,
   output reg O_SUB_CLOCK_DIV32,
   output reg O_BUS_CONTROLLER_CLOCK,
   output reg O_CLOCK_OUTPUT_PIN,
   output reg O_CLOCK_OUTPUT_PIN_OE_N,
   output reg O_LOW_POWER,
   output reg [2:0] O_SPEED_MODE
);

   // ==================================================================
   // Registers
   reg [6:0] clk_ctrl_ff;
   reg [4:0] cpu_div_ff;
   reg [2:0] mode_ff;
   reg [5:0] presc_ff;
   reg [1:0] protect_ff;
   reg ack_ff;
   reg [31:0] nxt_rdat;
   reg [1:0] cur_src_ff;
   reg [4:0] cur_ratio_ff;
   reg [3:0] cpu_cnt_ff;
   reg [4:0] f8_cnt_ff;
   reg [4:0] f32_cnt_ff;
   reg [14:0] f2n_cnt_ff;
   reg [4:0] sub_clock_div32_cnt_ff;
   reg forced_ff;

   wire [1:0] out_sel = clk_ctrl_ff[`CCG_CC_OUT_SEL_HI:`CCG_CC_OUT_SEL_LO];
   wire stop_in_wait = clk_ctrl_ff[`CCG_CC_STOP_WAIT];
   wire sub_sel = clk_ctrl_ff[`CCG_CC_SUB_SEL];
   wire pll_sel = clk_ctrl_ff[`CCG_CC_PLL_SEL];
   wire oco_sel = clk_ctrl_ff[`CCG_CC_OCO_SEL];
   wire direct_sel = clk_ctrl_ff[`CCG_CC_DIRECT_SEL];
   wire out_en = mode_ff[`CCG_MD_OUT_EN];
   wire [1:0] bus_fn = mode_ff[`CCG_MD_BUS_FN_HI:`CCG_MD_BUS_FN_LO];
   wire [3:0] f2n_exp = presc_ff[`CCG_PS_EXP_HI:`CCG_PS_EXP_LO];
   wire [1:0] f2n_src = presc_ff[`CCG_PS_SRC_HI:`CCG_PS_SRC_LO];
   wire clk_unlock = protect_ff[`CCG_PR_CLK_UNLOCK];
   wire mode_unlock = protect_ff[`CCG_PR_MODE_UNLOCK];

   // ==================================================================
   // Wishbone slave
   wire req = I_WB_CYC & I_WB_STB;
   wire wr_commit = req & I_WB_WE & ack_ff & I_WB_SEL[0];
   wire legal_div = (I_WB_DAT[4:0] == 5'h01) | (I_WB_DAT[4:0] == 5'h02) |
      (I_WB_DAT[4:0] == 5'h03) | (I_WB_DAT[4:0] == 5'h04) |
      (I_WB_DAT[4:0] == 5'h06) | (I_WB_DAT[4:0] == 5'h08) |
      (I_WB_DAT[4:0] == 5'h0A) | (I_WB_DAT[4:0] == 5'h0C) |
      (I_WB_DAT[4:0] == 5'h0E) | (I_WB_DAT[4:0] == 5'h10);

   always @* begin
      case (I_WB_ADR)
         `CCG_ADR_CLK_CTRL: nxt_rdat = {25'h0, clk_ctrl_ff};
         `CCG_ADR_CPU_DIV: nxt_rdat = {27'h0, cpu_div_ff};
         `CCG_ADR_MODE: nxt_rdat = {29'h0, mode_ff};
         `CCG_ADR_PRESC: nxt_rdat = {26'h0, presc_ff};
         `CCG_ADR_PROTECT: nxt_rdat = {30'h0, protect_ff};
         `CCG_ADR_STATUS: nxt_rdat = {26'h0, I_SUB_RUN, I_MAIN_RUN,
            low_power, O_SPEED_MODE};
         default: nxt_rdat = 32'h00000000;
      endcase
   end

   // ==================================================================
   // Mode decode
   // Low-power entry
   wire low_power = sub_sel & ~I_MAIN_RUN;
   wire periph_stop = (I_WAIT_MODE & stop_in_wait) | low_power | I_STOP_MODE;
   wire cpu_stop = I_WAIT_MODE | I_STOP_MODE;
   wire force_div = (I_STOP_MODE | low_power) & ~oco_sel;

   reg [2:0] nxt_speed;
   always @* begin
      if (sub_sel) begin
         nxt_speed = I_MAIN_RUN ? `CCG_SPD_LOW : `CCG_SPD_LOW_POWER;
      end else if (oco_sel) begin
         nxt_speed = I_MAIN_RUN ? `CCG_SPD_OCO : `CCG_SPD_OCO_LOW_POWER;
      end else if (direct_sel | (cpu_div_ff == `CCG_DIV_ONE)) begin
         nxt_speed = `CCG_SPD_HIGH;
      end else begin
         nxt_speed = `CCG_SPD_MEDIUM;
      end
   end

   // ==================================================================
   // CPU source and ratio selection
   reg [1:0] nxt_src;
   reg [4:0] nxt_ratio;
   always @* begin
      if (sub_sel) begin
         nxt_src = `CCG_SRC_SUB;
      end else if (oco_sel) begin
         nxt_src = `CCG_SRC_OCO;
      end else if (pll_sel) begin
         nxt_src = `CCG_SRC_PLL;
      end else begin
         nxt_src = `CCG_SRC_MAIN;
      end
      if (sub_sel | (direct_sel & ~oco_sel & ~pll_sel)) begin
         nxt_ratio = `CCG_DIV_ONE;
      end else begin
         nxt_ratio = cpu_div_ff;
      end
   end

   reg cur_tick;
   always @* begin
      case (cur_src_ff)
         `CCG_SRC_MAIN: cur_tick = I_MAIN_TICK;
         `CCG_SRC_SUB: cur_tick = I_SUB_TICK;
         `CCG_SRC_OCO: cur_tick = I_OCO_TICK;
         `CCG_SRC_PLL: cur_tick = I_PLL_TICK;
         default: cur_tick = I_MAIN_TICK;
      endcase
   end

   wire cpu_last = (cpu_cnt_ff == (cur_ratio_ff[3:0] - 4'h1)) |
      (cur_ratio_ff == `CCG_DIV_ONE) | (cur_ratio_ff == 5'h10 & cpu_cnt_ff == 4'hF);
   wire cpu_tick = cur_tick & cpu_last;

   // ==================================================================
   // Peripheral source
   // Peripherals on undivided clock
   wire periph_src = oco_sel ? I_OCO_TICK : (pll_sel ? I_PLL_TICK : I_MAIN_TICK);
   wire periph_tick = periph_src & ~periph_stop;

   reg f2n_src_tick;
   reg f2n_gate;
   always @* begin
      case (f2n_src)
         `CCG_FDS_PERIPH: begin
            f2n_src_tick = periph_src;
            f2n_gate = ~periph_stop;
         end
         `CCG_FDS_MAIN: begin
            f2n_src_tick = I_MAIN_TICK;
            f2n_gate = ~I_STOP_MODE;
         end
         `CCG_FDS_OCO: begin
            f2n_src_tick = I_OCO_TICK;
            f2n_gate = ~I_STOP_MODE;
         end
         default: begin
            f2n_src_tick = periph_src;
            f2n_gate = ~periph_stop;
         end
      endcase
   end
   wire f2n_step = f2n_src_tick & f2n_gate;

   wire [14:0] f2n_mask;
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi = gi + 1) begin : g_mask
         assign f2n_mask[gi] = (f2n_exp > gi);
      end
   endgenerate
   wire f2n_last = ((f2n_cnt_ff & f2n_mask) == f2n_mask);

   wire sub_tick = I_SUB_TICK & I_SUB_RUN & ~I_STOP_MODE;

   // ==================================================================
   // Clock output pin selection
   reg nxt_clock_output_pin;
   reg nxt_oe_n;
   always @* begin
      nxt_clock_output_pin = 1'b0;
      nxt_oe_n = 1'b0;
      if (I_EXP_MODE) begin
         if (bus_fn == `CCG_BUS_FN_ALE) begin
            nxt_clock_output_pin = I_ADDR_LATCH_STROBE;
         end else if (~out_en) begin
            nxt_clock_output_pin = cpu_tick & ~cpu_stop;
         end else begin
            case (out_sel)
               `CCG_OUT_PORT: nxt_clock_output_pin = 1'b0;
               `CCG_OUT_SUB: nxt_clock_output_pin = sub_tick;
               `CCG_OUT_F8: nxt_clock_output_pin = periph_tick & (f8_cnt_ff == `CCG_F8_LAST);
               `CCG_OUT_F32: nxt_clock_output_pin = periph_tick & (f32_cnt_ff == `CCG_F32_LAST);
               default: nxt_clock_output_pin = 1'b0;
            endcase
         end
      end else begin
         case (out_sel)
            `CCG_OUT_SUB: nxt_clock_output_pin = sub_tick;
            `CCG_OUT_F8: nxt_clock_output_pin = periph_tick & (f8_cnt_ff == `CCG_F8_LAST);
            `CCG_OUT_F32: nxt_clock_output_pin = periph_tick & (f32_cnt_ff == `CCG_F32_LAST);
            default: nxt_clock_output_pin = 1'b0;
         endcase
         nxt_oe_n = ~out_en | (out_sel == `CCG_OUT_PORT);
      end
   end

   // ==================================================================
   // Register file and bus answer
   always @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         clk_ctrl_ff <= `CCG_RST_CLK_CTRL;
         cpu_div_ff <= `CCG_RST_CPU_DIV;
         mode_ff <= `CCG_RST_MODE;
         presc_ff <= `CCG_RST_PRESC;
         protect_ff <= `CCG_RST_PROTECT;
         ack_ff <= 1'b0;
         forced_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
         forced_ff <= force_div;
         if (wr_commit & clk_unlock & (I_WB_ADR == `CCG_ADR_CLK_CTRL)) begin
            clk_ctrl_ff <= I_WB_DAT[6:0];
         end
         if (force_div & ~forced_ff) begin
            cpu_div_ff <= `CCG_DIV_BY_EIGHT;
         end else if (wr_commit & clk_unlock & legal_div &
               (I_WB_ADR == `CCG_ADR_CPU_DIV)) begin
            cpu_div_ff <= I_WB_DAT[4:0];
         end
         if (wr_commit & mode_unlock & (I_WB_ADR == `CCG_ADR_MODE)) begin
            mode_ff <= I_WB_DAT[2:0];
         end
         if (wr_commit & (I_WB_ADR == `CCG_ADR_PRESC)) begin
            presc_ff <= I_WB_DAT[5:0];
         end
         if (wr_commit & (I_WB_ADR == `CCG_ADR_PROTECT)) begin
            protect_ff <= I_WB_DAT[1:0];
         end
      end
   end

   // ==================================================================
   // Dividers
   always @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         cur_src_ff <= `CCG_SRC_MAIN;
         cur_ratio_ff <= `CCG_RST_CPU_DIV;
         cpu_cnt_ff <= 4'h0;
         f8_cnt_ff <= 5'h00;
         f32_cnt_ff <= 5'h00;
         f2n_cnt_ff <= 15'h0000;
         sub_clock_div32_cnt_ff <= 5'h00;
      end else begin
         if (cpu_tick) begin
            cpu_cnt_ff <= 4'h0;
            cur_src_ff <= nxt_src;
            cur_ratio_ff <= nxt_ratio;
         end else if (cur_tick) begin
            cpu_cnt_ff <= cpu_cnt_ff + 4'h1;
         end
         if (periph_tick) begin
            f8_cnt_ff <= (f8_cnt_ff == `CCG_F8_LAST) ? 5'h00 : f8_cnt_ff + 5'h01;
            f32_cnt_ff <= f32_cnt_ff + 5'h01;
         end
         if (f2n_step) begin
            f2n_cnt_ff <= f2n_last ? 15'h0000 : f2n_cnt_ff + 15'h0001;
         end
         if (sub_tick) begin
            sub_clock_div32_cnt_ff <= sub_clock_div32_cnt_ff + 5'h01;
         end
      end
   end

   // ==================================================================
   // Registered outputs
   always @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_WB_DAT <= 32'h00000000;
         O_WB_ACK <= 1'b0;
         O_CPU_CLK <= 1'b0;
         O_WDT_CLK <= 1'b0;
         O_BUS_CLK <= 1'b0;
         O_F1 <= 1'b0;
         O_F8 <= 1'b0;
         O_F32 <= 1'b0;
         O_F2N <= 1'b0;
         O_FAD <= 1'b0;
         O_SUB_CLOCK_DIV32 <= 1'b0;
         O_BUS_CONTROLLER_CLOCK <= 1'b0;
         O_CLOCK_OUTPUT_PIN <= 1'b0;
         O_CLOCK_OUTPUT_PIN_OE_N <= 1'b1;
         O_LOW_POWER <= 1'b0;
         O_SPEED_MODE <= `CCG_SPD_MEDIUM;
      end else begin
         O_WB_DAT <= (req & ~ack_ff & ~I_WB_WE) ? nxt_rdat : O_WB_DAT;
         O_WB_ACK <= req & ~ack_ff;
         O_CPU_CLK <= cpu_tick & ~cpu_stop;
         O_WDT_CLK <= cpu_tick & ~cpu_stop;
         O_BUS_CLK <= cpu_tick & ~cpu_stop & I_EXP_MODE;
         O_F1 <= periph_tick;
         O_F8 <= periph_tick & (f8_cnt_ff == `CCG_F8_LAST);
         O_F32 <= periph_tick & (f32_cnt_ff == `CCG_F32_LAST);
         O_F2N <= f2n_step & f2n_last;
         O_FAD <= periph_tick;
         // Sub divided clock in all modes except stop
         O_SUB_CLOCK_DIV32 <= sub_tick & (sub_clock_div32_cnt_ff == `CCG_SUB_CLOCK_DIV32_LAST);
         O_BUS_CONTROLLER_CLOCK <= I_MAIN_TICK & ~I_STOP_MODE;
         O_CLOCK_OUTPUT_PIN <= nxt_clock_output_pin;
         O_CLOCK_OUTPUT_PIN_OE_N <= nxt_oe_n;
         O_LOW_POWER <= low_power;
         O_SPEED_MODE <= nxt_speed;
      end
   end

endmodule // ccg_clock_gen

// ==== design/ccg_consts.vh ====
// Purpose: Constants for the CPU and peripheral clock generator
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef CCG_CONSTS_VH
`define CCG_CONSTS_VH

// =====================================================================
// Register byte offsets
`define CCG_ADR_CLK_CTRL 8'h00
`define CCG_ADR_CPU_DIV 8'h04
`define CCG_ADR_MODE 8'h08
`define CCG_ADR_PRESC 8'h0C
`define CCG_ADR_PROTECT 8'h10
`define CCG_ADR_STATUS 8'h14

// =====================================================================
// Clock control field positions
`define CCG_CC_OUT_SEL_LO 0
`define CCG_CC_OUT_SEL_HI 1
`define CCG_CC_STOP_WAIT 2
`define CCG_CC_SUB_SEL 3
`define CCG_CC_PLL_SEL 4
`define CCG_CC_OCO_SEL 5
`define CCG_CC_DIRECT_SEL 6
// Mode register field positions
`define CCG_MD_OUT_EN 0
`define CCG_MD_BUS_FN_LO 1
`define CCG_MD_BUS_FN_HI 2
// Prescaler field positions
`define CCG_PS_EXP_LO 0
`define CCG_PS_EXP_HI 3
`define CCG_PS_SRC_LO 4
`define CCG_PS_SRC_HI 5
// Protect field positions
`define CCG_PR_CLK_UNLOCK 0
`define CCG_PR_MODE_UNLOCK 1

// =====================================================================
// Reset values
`define CCG_RST_CLK_CTRL 7'h00
`define CCG_RST_CPU_DIV 5'h08
`define CCG_RST_MODE 3'h0
`define CCG_RST_PRESC 6'h00
`define CCG_RST_PROTECT 2'h0

// =====================================================================
// Divider figures
`define CCG_DIV_BY_EIGHT 5'h08
`define CCG_DIV_ONE 5'h01
`define CCG_F8_LAST 5'h07
`define CCG_F32_LAST 5'h1F
`define CCG_SUB_CLOCK_DIV32_LAST 5'h1F

// =====================================================================
// CPU source codes
`define CCG_SRC_MAIN 2'h0
`define CCG_SRC_SUB 2'h1
`define CCG_SRC_OCO 2'h2
`define CCG_SRC_PLL 2'h3

// Pin function codes
`define CCG_OUT_PORT 2'h0
`define CCG_OUT_SUB 2'h1
`define CCG_OUT_F8 2'h2
`define CCG_OUT_F32 2'h3
`define CCG_BUS_FN_ALE 2'h1

// Fixed divider source codes
`define CCG_FDS_PERIPH 2'h0
`define CCG_FDS_MAIN 2'h1
`define CCG_FDS_OCO 2'h2

// Speed modes
`define CCG_SPD_HIGH 3'h0
`define CCG_SPD_MEDIUM 3'h1
`define CCG_SPD_LOW 3'h2
`define CCG_SPD_LOW_POWER 3'h3
`define CCG_SPD_OCO 3'h4
`define CCG_SPD_OCO_LOW_POWER 3'h5

`endif

// ==== bench/ccg_clock_gen_assertions.sv ====
// Purpose: Port checker for the clock generator
// Assumes: Source ticks are one-cycle enables on the core clock
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`include "ccg_consts.vh"
module ccg_clock_gen_assertions (
   input wire I_CORE_CLK,
   input wire I_SYS_RST,
   input wire I_MAIN_TICK,
   input wire I_SUB_TICK,
   input wire I_SUB_RUN,
   input wire I_WAIT_MODE,
   input wire I_STOP_MODE,
   input wire O_CPU_CLK,
   input wire O_WDT_CLK,
   input wire O_BUS_CLK,
   input wire O_F1,
   input wire O_F8,
   input wire O_F32,
   input wire O_FAD,
   input wire O_SUB_CLOCK_DIV32,
   input wire O_BUS_CONTROLLER_CLOCK,
   input wire O_LOW_POWER,
   input wire [2:0] O_SPEED_MODE
);
   // ==========================================================
   // Pulse counters
   reg [4:0] f8c_ff;
   reg [4:0] f32c_ff;
   reg [4:0] sc_ff;
   reg [3:0] mt_ff;
   reg seen_ff;
   always @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         f8c_ff <= 5'h00;
         f32c_ff <= 5'h00;
         sc_ff <= 5'h00;
         mt_ff <= 4'h0;
         seen_ff <= 1'b0;
      end else begin
         f8c_ff <= O_F8 ? 5'h00 : f8c_ff + {4'h0, O_F1};
         f32c_ff <= O_F32 ? 5'h00 : f32c_ff + {4'h0, O_F1};
         sc_ff <= sc_ff + {4'h0, I_SUB_TICK & I_SUB_RUN & !I_STOP_MODE};
         mt_ff <= (mt_ff == 4'hF) ? mt_ff : mt_ff + {3'h0, I_MAIN_TICK};
         seen_ff <= seen_ff | O_CPU_CLK;
      end
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   // ==========================================================
   // Properties
   a_cpu_first_div: assert property (O_CPU_CLK && !seen_ff |-> mt_ff == 4'h8)
      else $error("first cpu pulse not after eight main ticks");
   a_wdt_is_cpu: assert property (O_WDT_CLK == O_CPU_CLK)
      else $error("watchdog clock differs from cpu clock");
   a_bus_needs_cpu: assert property (O_BUS_CLK |-> O_CPU_CLK)
      else $error("bus clock without cpu clock");
   a_f8_ratio: assert property (O_F8 |-> O_F1 && f8c_ff == 5'h07)
      else $error("f8 not every eighth f1");
   a_f32_ratio: assert property (O_F32 |-> O_F1 && f32c_ff == 5'h1F)
      else $error("f32 not every thirty-second f1");
   a_lp_gates_periph: assert property (O_LOW_POWER |-> !(O_F1 || O_F8 || O_F32 || O_FAD))
      else $error("peripheral clock in low power");
   a_sub_div32: assert property (O_SUB_CLOCK_DIV32 |-> $past(I_SUB_TICK) && sc_ff == 5'h00)
      else $error("sub divided clock off ratio");
   a_can_follows: assert property (I_MAIN_TICK && !I_STOP_MODE |=> O_BUS_CONTROLLER_CLOCK)
      else $error("bus controller clock missed a main tick");
   a_can_only_main: assert property (O_BUS_CONTROLLER_CLOCK |-> $past(I_MAIN_TICK))
      else $error("bus controller clock without main tick");
   a_cpu_held: assert property (I_WAIT_MODE || I_STOP_MODE |=> !O_CPU_CLK)
      else $error("cpu pulse in wait or stop");
   a_lp_speed: assert property (O_LOW_POWER |-> O_SPEED_MODE == `CCG_SPD_LOW_POWER)
      else $error("low power flag with wrong speed mode");
endmodule // ccg_clock_gen_assertions

// ==== bench/ccg_osc_model.sv ====
// Purpose: Oscillator sources as tick enables
// Assumes: Periods counted in core clock cycles
// Notes: Main and PLL ticks halt while main is off
`timescale 1ns/1ps
module ccg_osc_model #(
   parameter MAIN_P = 2,
   parameter SUB_P = 5,
   parameter OCO_P = 3
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_main_on,
   input wire i_sub_on,
   output reg o_main_tick,
   output reg o_sub_tick,
   output reg o_oco_tick,
   output reg o_pll_tick
);
   integer m_ff;
   integer s_ff;
   integer o_ff;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         m_ff <= 0;
         s_ff <= 0;
         o_ff <= 0;
         o_main_tick <= 1'b0;
         o_sub_tick <= 1'b0;
         o_oco_tick <= 1'b0;
         o_pll_tick <= 1'b0;
      end else begin
         m_ff <= (m_ff + 1) % MAIN_P;
         s_ff <= (s_ff + 1) % SUB_P;
         o_ff <= (o_ff + 1) % OCO_P;
         o_main_tick <= i_main_on && m_ff == 0;
         o_sub_tick <= i_sub_on && s_ff == 0;
         o_oco_tick <= o_ff == 0;
         o_pll_tick <= i_main_on;
      end
   end
endmodule // ccg_osc_model

// ==== bench/tb_ccg_clock_gen.sv ====
// Purpose: Self-checking bench for the clock generator
// Assumes: Main ticks every 2 cycles, sub every 5, on-chip every 3
// Notes: Register reads are checked by a queue monitor
`timescale 1ns/1ps
`include "ccg_consts.vh"
module tb_ccg_clock_gen;
   reg clk, rst, cyc, stb, we, main_on, sub_on, wait_m, exp_m, ale;
   reg [7:0] adr;
   reg [3:0] sel, ws;
   reg stop_m;
   reg [31:0] dat;
   reg [31:0] sd;
   wire [31:0] rdat;
   wire ack, mt, st, ot, pt, cpu, f1, f2n, fad, clko, oe_n;
   logic [31:0] q[$];
   int i, g, v, d, k_out, k_f1, k_fad, k_f2n, err_total, compares;
   int dv[10] = '{1, 2, 3, 4, 6, 8, 10, 12, 14, 16};
   int sv[4] = '{32'h40, 32'h20, 32'h10, 32'h08};
   int sg[4] = '{2, 12, 4, 5};
   int sp[4] = '{0, 4, 1, 2};
   int ko[4] = '{0, 64, 20, 5};
   ccg_osc_model u_ccg_osc_model (.i_clk(clk), .i_rst(rst), .i_main_on(main_on),
      .i_sub_on(sub_on), .o_main_tick(mt), .o_sub_tick(st), .o_oco_tick(ot), .o_pll_tick(pt));
   ccg_clock_gen u_ccg_clock_gen (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_MAIN_TICK(mt), .I_SUB_TICK(st), .I_OCO_TICK(ot),
      .I_PLL_TICK(pt), .I_MAIN_RUN(main_on), .I_SUB_RUN(sub_on), .I_WAIT_MODE(wait_m),
      .I_STOP_MODE(stop_m), .I_EXP_MODE(exp_m), .I_ADDR_LATCH_STROBE(ale), .O_CPU_CLK(cpu),
      .O_WDT_CLK(), .O_BUS_CLK(), .O_F1(f1), .O_F8(), .O_F32(), .O_F2N(f2n), .O_FAD(fad),
      .O_SUB_CLOCK_DIV32(), .O_BUS_CONTROLLER_CLOCK(), .O_CLOCK_OUTPUT_PIN(clko), .O_CLOCK_OUTPUT_PIN_OE_N(oe_n), .O_LOW_POWER(),
      .O_SPEED_MODE());
   // ==========================================================
   // Tasks
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      begin
         compares++;
         if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task test_done;
      begin
         $display("compares %0d err_total %0d", compares, err_total);
         if (err_total == 0 && compares > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   function automatic int lf();
      sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
      return sd[15:0];
   endfunction
   task wb(input logic w, input logic [7:0] a, input logic [31:0] x);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat <= x;
         sel <= ws;
         @(posedge clk);
         while (ack !== 1'b1) @(posedge clk);
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] x);
      wb(1'b1, a, x);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      begin
         q.push_back(e);
         wb(1'b0, a, 32'h0);
      end
   endtask
   task gap(output int n);
      begin
         @(negedge clk);
         while (cpu !== 1'b1) @(negedge clk);
         @(negedge clk);
         n = 1;
         while (cpu !== 1'b1) begin
            n++;
            @(negedge clk);
         end
      end
   endtask
   task cnt(input int n);
      begin
         k_out = 0; k_f1 = 0; k_fad = 0; k_f2n = 0;
         repeat (n) begin
            @(negedge clk);
            k_out += clko; k_f1 += f1; k_fad += fad; k_f2n += f2n;
         end
         @(posedge clk);
      end
   endtask
   // ==========================================================
   // Read monitor, clock and watchdog
   always @(posedge clk) begin
      if (ack === 1'b1 && !we && q.size() > 0) chk("read_data", q.pop_front(), rdat);
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      test_done;
   end
   // ==========================================================
   // Scenarios
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
      main_on = 1'b1; sub_on = 1'b0; wait_m = 1'b0; exp_m = 1'b0; ale = 1'b0;
      stop_m = 1'b0; sel = 4'hF; ws = 4'hF;
      sd = 32'd80154;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`CCG_ADR_CLK_CTRL, 0);
      rd(`CCG_ADR_CPU_DIV, 8);
      rd(`CCG_ADR_MODE, 0);
      rd(`CCG_ADR_PRESC, 0);
      rd(`CCG_ADR_PROTECT, 0);
      rd(`CCG_ADR_STATUS, 32'h11);
      rd(8'h20, 0);
      gap(g);
      gap(g);
      chk("cpu_gap", 16, g);
      wr(`CCG_ADR_CPU_DIV, 4);
      rd(`CCG_ADR_CPU_DIV, 8);
      $display("test reset and lock done");
      wr(`CCG_ADR_PROTECT, 3);
      ws = 4'h0;
      wr(`CCG_ADR_CPU_DIV, 2);
      ws = 4'hF;
      rd(`CCG_ADR_CPU_DIV, 8);
      d = 8;
      for (i = 0; i < 6; i++) begin
         v = lf() % 32;
         if (v inside {1, 2, 3, 4, 6, 8, 10, 12, 14, 16}) d = v;
         wr(`CCG_ADR_CPU_DIV, v);
         rd(`CCG_ADR_CPU_DIV, d);
      end
      foreach (dv[j]) begin
         wr(`CCG_ADR_CPU_DIV, dv[j]);
         gap(g);
         gap(g);
         chk("cpu_gap", 2 * dv[j], g);
      end
      $display("test divider done");
      wr(`CCG_ADR_CPU_DIV, 4);
      sub_on <= 1'b1;
      for (i = 0; i < 4; i++) begin
         wr(`CCG_ADR_CLK_CTRL, sv[i]);
         gap(g);
         gap(g);
         chk("src_gap", sg[i], g);
         rd(`CCG_ADR_STATUS, sp[i] + 32'h30);
      end
      main_on <= 1'b0;
      repeat (20) @(posedge clk);
      rd(`CCG_ADR_STATUS, 32'h2B);
      rd(`CCG_ADR_CPU_DIV, 8);
      gap(g);
      chk("lp_gap", 5, g);
      cnt(40);
      chk("f1_lp", 0, k_f1);
      main_on <= 1'b1;
      wr(`CCG_ADR_CLK_CTRL, 0);
      $display("test sources done");
      for (i = 0; i < 2; i++) begin
         wr(`CCG_ADR_CLK_CTRL, 4 * (1 - i));
         wait_m <= 1'b1;
         repeat (2) @(posedge clk);
         cnt(40);
         wait_m <= 1'b0;
         chk("f1_wait", 20 * i, k_f1);
         chk("fad_wait", 20 * i, k_fad);
      end
      wr(`CCG_ADR_CPU_DIV, 2);
      stop_m <= 1'b1;
      repeat (2) @(posedge clk);
      rd(`CCG_ADR_CPU_DIV, 8);
      cnt(20);
      stop_m <= 1'b0;
      chk("f1_stop", 0, k_f1);
      for (i = 0; i < 3; i++) begin
         v = lf() % 5;
         wr(`CCG_ADR_PRESC, 32'h10 + v);
         repeat (80) @(posedge clk);
         cnt(64);
         chk("f2n", 32 >> v, k_f2n);
      end
      $display("test peripheral clocks done");
      wr(`CCG_ADR_MODE, 1);
      for (i = 1; i < 4; i++) begin
         wr(`CCG_ADR_CLK_CTRL, i);
         repeat (80) @(posedge clk);
         cnt(320);
         chk("pin_count", ko[i], k_out);
         chk("pin_oe", 0, oe_n);
      end
      wr(`CCG_ADR_CLK_CTRL, 0);
      repeat (3) @(posedge clk);
      chk("pin_oe", 1, oe_n);
      exp_m <= 1'b1;
      wr(`CCG_ADR_MODE, 0);
      repeat (40) @(posedge clk);
      cnt(320);
      chk("pin_bus", 20, k_out);
      wr(`CCG_ADR_MODE, 1);
      repeat (3) @(posedge clk);
      cnt(40);
      chk("pin_low", 0, k_out);
      chk("pin_oe", 0, oe_n);
      wr(`CCG_ADR_MODE, 2);
      for (i = 0; i < 2; i++) begin
         ale <= 1 - i;
         repeat (3) @(posedge clk);
         chk("pin_ale", 1 - i, clko);
      end
      $display("test clock pin done");
      test_done;
   end
endmodule // tb_ccg_clock_gen
bind ccg_clock_gen ccg_clock_gen_assertions u_ccg_clock_gen_assertions (
   .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_MAIN_TICK(I_MAIN_TICK),
   .I_SUB_TICK(I_SUB_TICK), .I_SUB_RUN(I_SUB_RUN), .I_WAIT_MODE(I_WAIT_MODE),
   .I_STOP_MODE(I_STOP_MODE), .O_CPU_CLK(O_CPU_CLK), .O_WDT_CLK(O_WDT_CLK),
   .O_BUS_CLK(O_BUS_CLK), .O_F1(O_F1), .O_F8(O_F8), .O_F32(O_F32), .O_FAD(O_FAD),
   .O_SUB_CLOCK_DIV32(O_SUB_CLOCK_DIV32), .O_BUS_CONTROLLER_CLOCK(O_BUS_CONTROLLER_CLOCK), .O_LOW_POWER(O_LOW_POWER), .O_SPEED_MODE(O_SPEED_MODE));
